// ==== pkg/vsu_pkg.sv ====
package vsu_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 32'h017d7840;   // 25 MHz
  localparam int unsigned TICK_MS = 32'h0000000a;  // Time base of 10 ms
  localparam int unsigned MS_PER_S = 32'h000003e8;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int unsigned TICKS_PER_S = MS_PER_S / TICK_MS;
  localparam logic [15:0] BREAK_MAX = 16'h1770;    // 60 s in ticks
  localparam logic [15:0] TRANSIT_MAX = 16'h4650;  // 180 s in ticks
  localparam logic [15:0] TCNT_MAX = 16'hffff;
  localparam logic [6:0] DEV_MAX = 7'h64;          // 100 %
  localparam logic [6:0] DEV_RST = 7'h1e;          // 30 %
  localparam logic [19:0] PERIOD_MIN = 20'h0000a;  // 10 s
  localparam logic [19:0] PERIOD_MAX = 20'ha8bff;  // 7 d 23:59:59
  localparam logic [19:0] PERIOD_RST = 20'h15180;  // One day
  localparam logic [19:0] IDLE_MAX = 20'hfffff;
  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SETPT = 8'h04;
  localparam logic [7:0] ADDR_REF0 = 8'h08;
  localparam logic [7:0] ADDR_MEAS0 = 8'h18;
  localparam logic [7:0] ADDR_PERIOD = 8'h28;
  localparam logic [7:0] ADDR_STROKE = 8'h2c;
  localparam logic [7:0] ADDR_LIMIT = 8'h30;
  localparam logic [7:0] ADDR_LEADMON = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_ALERT = 8'h3c;
  // Control fields
  localparam int CB_MODE = 0;
  localparam int CB_TM = 2;
  localparam int CB_TOPEN = 3;
  localparam int CB_TCLOSED = 4;
  localparam int CB_STROKE = 5;
  localparam int CB_SUBA = 6;
  localparam int CB_VALA = 7;
  localparam int CB_SUBB = 8;
  localparam int CB_VALB = 9;
  localparam int CB_MAN = 10;
  localparam int CTRL_W = 11;
  localparam logic [10:0] CTRL_RST = 11'h000;
  localparam int SP_GOOD = 8;
  localparam int REF_DEV = 16;
  // Mode codes
  localparam logic [1:0] MODE_OUT_OF_SERVICE = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_MANUAL = 2'h2;
  // Lead fault layout
  localparam int LF_SC_A = 0;
  localparam int LF_LB_A = 1;
  localparam int LF_SC_B = 2;
  localparam int LF_LB_B = 3;
  localparam int LF_SC_V = 4;
  localparam int LF_LB_V = 5;
  // Supervision states
  typedef enum logic [2:0] {ST_IDLE, ST_BREAK, ST_TRANSIT, ST_TEST_BREAK, ST_TEST_RETURN} vsu_state_t;
endpackage : vsu_pkg

// ==== verilog/vsu_sync.sv ====
`timescale 1ns/1ps
module vsu_sync #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // ------------------------------------------------------------
  // Three-stage synchroniser per bit
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // Output moves only once stages two and three agree
      always_ff @(posedge i_mclk)
      begin
        if (i_rst)
        begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          o_q[g] <= 1'b0;
        end
        else
        begin
          s1 <= i_d[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
            o_q[g] <= s3;
        end
      end
    end
  endgenerate
endmodule : vsu_sync

// ==== verilog/vsu_top.sv ====
`timescale 1ns/1ps
// How it works
// R1: Three modes, out of service after reset
// R2: Out of service: idle, valve not driven
// R3: Automatic mode follows configured supervision
// R4: Time supervision measures on setpoint change
// R5: Alarm when time leaves tolerance window
// R6: Last measured times held for readback
// R7: Four references, each with own deviation
// R8: Reference and deviation ranges clamped
// R9: Measurement resolution 10 ms tick
// R10: Setup loads references, deviation 30 percent; here reset zeroes references, sets deviation 30
// R11: Function test only with time supervision
// R12: Test drives opposite until breakaway, returns
// R13: Test breakaway stored and checked
// R14: Separate test enables open and closed
// R15: Test starts after unchanged setpoint interval
// R16: Stroke counted on open-closed-open cycle
// R17: Stroke count presettable, survives by restore
// R18: Maintenance alarm above limit, zero disables
// R19: Six lead fault monitor enables
// R20: Lead fault status matches enable layout
// R21: Sensor substitution on lead fault
// R22: Sixteen-bit plant unit alert key
// R23: High current contact reads as one
// R24: Zero setpoint closed; only good status
// R25: Breakaway to contact release, then transit
module vsu_top #(
  parameter int unsigned TICK_CYCLES = vsu_pkg::TICK_CYCLES
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_fb_a,
  input wire logic i_fb_b,
  input wire logic [5:0] i_lead_det,
  output logic o_valve,
  output logic o_test_active,
  output logic o_maint_alarm
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [vsu_pkg::CTRL_W-1:0] ctrl;
  logic [8:0] setpt;
  logic cmd;
  logic [19:0] period;
  logic [31:0] stroke_cnt;
  logic [31:0] stroke_lim;
  logic [5:0] lead_mon;
  logic [5:0] lead_fault;
  logic [15:0] alert_key;
  logic [15:0] ref_t [4];
  logic [6:0] dev [4];
  logic [15:0] meas [4];
  logic [3:0] t_alm;
  logic [7:0] sync_q;
  logic [TW-1:0] tick_cnt;
  logic [6:0] sec_cnt;
  logic [15:0] tcnt;
  logic [19:0] idle_s;
  logic seen_closed;
  vsu_pkg::vsu_state_t state;
  vsu_pkg::vsu_state_t next_state;
  logic st_ba;
  logic st_tr;
  logic clr_t;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  vsu_sync #(.W(8)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d({i_lead_det, i_fb_b, i_fb_a}),
    .o_q(sync_q)
  );

  // ------------------------------------------------------------
  // Configuration fields and sensor view
  // ------------------------------------------------------------
  wire [1:0] mode = ctrl[vsu_pkg::CB_MODE +: 2];
  wire is_oos = (mode == vsu_pkg::MODE_OUT_OF_SERVICE);
  wire is_auto = (mode == vsu_pkg::MODE_AUTO);
  wire is_man = (mode == vsu_pkg::MODE_MANUAL);
  wire tm_en = ctrl[vsu_pkg::CB_TM];
  // R23: contact polarity
  wire fb_a_s = sync_q[0];
  wire fb_b_s = sync_q[1];
  // R20: fault status mirrors enables
  wire [5:0] next_lead_fault = sync_q[7:2] & lead_mon;
  wire fault_a = lead_fault[vsu_pkg::LF_SC_A] | lead_fault[vsu_pkg::LF_LB_A];
  wire fault_b = lead_fault[vsu_pkg::LF_SC_B] | lead_fault[vsu_pkg::LF_LB_B];
  // R21: fault value replaces sensor
  wire sens_a = (ctrl[vsu_pkg::CB_SUBA] & fault_a) ? ctrl[vsu_pkg::CB_VALA] : fb_a_s;
  wire sens_b = (ctrl[vsu_pkg::CB_SUBB] & fault_b) ? ctrl[vsu_pkg::CB_VALB] : fb_b_s;
  // Contact A marks open, contact B marks closed
  wire at_open = sens_a & ~sens_b;
  wire at_closed = ~sens_a & sens_b;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup = i_psel & ~i_penable;
  wire acc = i_psel & i_penable & o_pready;
  wire algn = (i_paddr[1:0] == 2'h0);
  wire a_ctrl = (i_paddr == vsu_pkg::ADDR_CTRL);
  wire a_setpt = (i_paddr == vsu_pkg::ADDR_SETPT);
  wire a_ref = algn && (i_paddr >= vsu_pkg::ADDR_REF0) && (i_paddr < vsu_pkg::ADDR_MEAS0);
  wire a_meas = algn && (i_paddr >= vsu_pkg::ADDR_MEAS0) && (i_paddr < vsu_pkg::ADDR_PERIOD);
  wire a_period = (i_paddr == vsu_pkg::ADDR_PERIOD);
  wire a_stroke = (i_paddr == vsu_pkg::ADDR_STROKE);
  wire a_limit = (i_paddr == vsu_pkg::ADDR_LIMIT);
  wire a_leadmon = (i_paddr == vsu_pkg::ADDR_LEADMON);
  wire a_status = (i_paddr == vsu_pkg::ADDR_STATUS);
  wire a_alert = (i_paddr == vsu_pkg::ADDR_ALERT);
  wire [7:0] ref_off = i_paddr - vsu_pkg::ADDR_REF0;
  wire [7:0] meas_off = i_paddr - vsu_pkg::ADDR_MEAS0;
  wire [1:0] ref_idx = ref_off[3:2];
  wire [1:0] meas_idx = meas_off[3:2];
  wire wr_hit = a_ctrl | a_setpt | a_ref | a_period | a_stroke | a_limit | a_leadmon | a_alert;
  wire rd_hit = wr_hit | a_meas | a_status;
  wire hit = i_pwrite ? wr_hit : rd_hit;
  wire wr = acc & i_pwrite & wr_hit;
  // Read-only offsets answer a write with an error
  wire [31:0] status = {17'h00000, sens_b, sens_a, (state != vsu_pkg::ST_IDLE),
                        o_test_active, o_maint_alarm, t_alm, lead_fault};
  wire [31:0] rd_data =
    a_ctrl ? {21'h000000, ctrl} :
    a_setpt ? {23'h000000, setpt} :
    a_ref ? {9'h000, dev[ref_idx], ref_t[ref_idx]} :
    a_meas ? {16'h0000, meas[meas_idx]} :
    a_period ? {12'h000, period} :
    a_stroke ? stroke_cnt :
    a_limit ? stroke_lim :
    a_leadmon ? {26'h0000000, lead_mon} :
    a_status ? status :
    a_alert ? {16'h0000, alert_key} : 32'h00000000;

  // No wait state: data latched in setup, ready in first access cycle
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready <= setup;
      o_prdata <= (setup & ~i_pwrite & rd_hit) ? rd_data : 32'h00000000;
      o_pslverr <= setup & ~hit;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  // R24: open/closed command taken only with good status
  wire sp_good = i_pwdata[vsu_pkg::SP_GOOD];
  wire sp_open = (i_pwdata[7:0] != 8'h00);
  wire cmd_chg = wr & a_setpt & sp_good & (sp_open != cmd);
  // R15: period clamped to legal interval
  wire [19:0] per_w = i_pwdata[19:0];
  wire [19:0] per_cl = (per_w < vsu_pkg::PERIOD_MIN) ? vsu_pkg::PERIOD_MIN :
                       (per_w > vsu_pkg::PERIOD_MAX) ? vsu_pkg::PERIOD_MAX : per_w;

  // R1: reset enters out of service
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ctrl <= vsu_pkg::CTRL_RST;
      setpt <= 9'h000;
      cmd <= 1'b0;
      period <= vsu_pkg::PERIOD_RST;
      stroke_lim <= 32'h00000000;
      lead_mon <= 6'h00;
      alert_key <= 16'h0000;
      lead_fault <= 6'h00;
    end
    else
    begin
      lead_fault <= next_lead_fault;
      if (wr & a_ctrl)
        ctrl <= i_pwdata[vsu_pkg::CTRL_W-1:0];
      if (wr & a_setpt)
        setpt <= i_pwdata[8:0];
      if (wr & a_setpt & sp_good)
        cmd <= sp_open;
      if (wr & a_period)
        period <= per_cl;
      if (wr & a_limit)
        stroke_lim <= i_pwdata;
      // R19: six independent lead enables
      if (wr & a_leadmon)
        lead_mon <= i_pwdata[5:0];
      // R22: alert key limited to 16 bits
      if (wr & a_alert)
        alert_key <= i_pwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  wire tick = (tick_cnt == TW'(TICK_CYCLES - 1));
  wire sec = tick & (sec_cnt == 7'(vsu_pkg::TICKS_PER_S - 1));

  // R9: 10 ms tick keeps error well inside 50 ms
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      tick_cnt <= '0;
      sec_cnt <= 7'h00;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick)
        sec_cnt <= sec ? 7'h00 : sec_cnt + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // Supervision state machine
  // ------------------------------------------------------------
  wire in_test = (state == vsu_pkg::ST_TEST_BREAK) | (state == vsu_pkg::ST_TEST_RETURN);
  // R12: test drives opposite, then back home
  wire move_open = (state == vsu_pkg::ST_TEST_BREAK) ? ~cmd : cmd;
  wire released = move_open ? ~at_closed : ~at_open;
  wire reached = move_open ? at_open : at_closed;
  wire home = cmd ? at_open : at_closed;
  // R14: per-position enables
  wire test_pos = (cmd & at_open & ctrl[vsu_pkg::CB_TOPEN]) | (~cmd & at_closed & ctrl[vsu_pkg::CB_TCLOSED]);
  wire test_go = tm_en & test_pos & (idle_s >= period);
  wire [1:0] st_idx = {~move_open, st_tr};

  // R25: breakaway ends at contact release, transit at target
  always_comb
  begin
    next_state = state;
    st_ba = 1'b0;
    st_tr = 1'b0;
    clr_t = 1'b0;
    // R2: outside automatic mode nothing is supervised
    if (!is_auto)
      next_state = vsu_pkg::ST_IDLE;
    else if (cmd_chg)
    begin
      // R4: every good-status command change restarts a measurement when tm_en is set
      next_state = tm_en ? vsu_pkg::ST_BREAK : vsu_pkg::ST_IDLE;
      clr_t = 1'b1;
    end
    // R11: no test without time supervision
    else if (!tm_en)
      next_state = vsu_pkg::ST_IDLE;
    else
    begin
      case (state)
        vsu_pkg::ST_IDLE:
          // R15: test after unchanged interval
          if (test_go)
          begin
            next_state = vsu_pkg::ST_TEST_BREAK;
            clr_t = 1'b1;
          end
        vsu_pkg::ST_BREAK:
          if (released)
          begin
            st_ba = 1'b1;
            clr_t = 1'b1;
            next_state = vsu_pkg::ST_TRANSIT;
          end
        vsu_pkg::ST_TRANSIT:
          if (reached)
          begin
            st_tr = 1'b1;
            next_state = vsu_pkg::ST_IDLE;
          end
        vsu_pkg::ST_TEST_BREAK:
          // R13: test breakaway stored like any other
          if (released)
          begin
            st_ba = 1'b1;
            next_state = vsu_pkg::ST_TEST_RETURN;
          end
        vsu_pkg::ST_TEST_RETURN:
          if (home)
            next_state = vsu_pkg::ST_IDLE;
        default:
          next_state = vsu_pkg::ST_IDLE;
      endcase
    end
  end

  // R3: valve follows mode, command and test
  wire next_valve = is_man ? ctrl[vsu_pkg::CB_MAN] :
                    !is_auto ? 1'b0 :
                    (next_state == vsu_pkg::ST_TEST_BREAK) ? ~cmd : cmd;

  // Idle seconds restart on a command change, outside automatic mode or after a test
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state <= vsu_pkg::ST_IDLE;
      tcnt <= 16'h0000;
      idle_s <= 20'h00000;
      o_valve <= 1'b0;
      o_test_active <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_valve <= next_valve;
      o_test_active <= (next_state == vsu_pkg::ST_TEST_BREAK) | (next_state == vsu_pkg::ST_TEST_RETURN);
      if (clr_t)
        tcnt <= 16'h0000;
      else if (tick && tcnt != vsu_pkg::TCNT_MAX)
        tcnt <= tcnt + 16'h0001;
      if (!is_auto || cmd_chg || in_test)
        idle_s <= 20'h00000;
      else if (sec && idle_s != vsu_pkg::IDLE_MAX)
        idle_s <= idle_s + 20'h00001;
    end
  end

  // ------------------------------------------------------------
  // References, measured times and time alarms
  // ------------------------------------------------------------
  // R5: window of reference plus and minus deviation
  function automatic logic out_of_win(input logic [15:0] m, input logic [15:0] r, input logic [6:0] d);
    logic [24:0] m100;
    logic [24:0] hi;
    logic [24:0] lo;
    begin
      m100 = 25'(m) * 25'(vsu_pkg::DEV_MAX);
      hi = 25'(r) * (25'(vsu_pkg::DEV_MAX) + 25'(d));
      lo = 25'(r) * (25'(vsu_pkg::DEV_MAX) - 25'(d));
      out_of_win = (m100 > hi) || (m100 < lo);
    end
  endfunction : out_of_win

  wire win_bad = out_of_win(tcnt, ref_t[st_idx], dev[st_idx]);
  wire [15:0] ref_w = i_pwdata[15:0];
  wire [6:0] dev_w = i_pwdata[vsu_pkg::REF_DEV +: 7];
  wire [6:0] dev_cl = (dev_w > vsu_pkg::DEV_MAX) ? vsu_pkg::DEV_MAX : dev_w;

  // R7: four independent entries
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_time
      // Even entries are breakaway, odd are transit
      localparam logic [15:0] LIM = (g % 2 == 0) ? vsu_pkg::BREAK_MAX : vsu_pkg::TRANSIT_MAX;
      always_ff @(posedge i_mclk)
      begin
        if (i_rst)
        begin
          ref_t[g] <= 16'h0000;
          dev[g] <= vsu_pkg::DEV_RST;
          meas[g] <= 16'h0000;
          t_alm[g] <= 1'b0;
        end
        else
        begin
          // R8: out-of-range writes clamp
          if (wr && a_ref && ref_idx == 2'(g))
          begin
            ref_t[g] <= (ref_w > LIM) ? LIM : ref_w;
            dev[g] <= dev_cl;
          end
          // R6: last value held, alarm follows it
          if ((st_ba | st_tr) && st_idx == 2'(g))
          begin
            meas[g] <= tcnt;
            t_alm[g] <= win_bad;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Stroke counter
  // ------------------------------------------------------------
  wire stroke_en = ctrl[vsu_pkg::CB_STROKE] & ~is_oos;
  wire stroke_inc = stroke_en & at_open & seen_closed;

  // R16: closed then open again adds one
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      stroke_cnt <= 32'h00000000;
      seen_closed <= 1'b0;
      o_maint_alarm <= 1'b0;
    end
    else
    begin
      // R17: preset write wins over a count
      if (wr & a_stroke)
        stroke_cnt <= i_pwdata;
      else if (stroke_inc)
        stroke_cnt <= stroke_cnt + 32'h00000001;
      if (!stroke_en || stroke_inc)
        seen_closed <= 1'b0;
      else if (at_closed)
        seen_closed <= 1'b1;
      // R18: zero limit disables alarm
      o_maint_alarm <= (stroke_lim != 32'h00000000) && (stroke_cnt > stroke_lim);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  AST_RESET_MODE: assert property ($fell(i_rst) |-> is_oos && !o_valve && state == vsu_pkg::ST_IDLE) // R1
    else $error("Reset did not leave out of service");
  AST_OOS_QUIET: assert property (is_oos [*2] |-> !o_valve && state == vsu_pkg::ST_IDLE) // R2
    else $error("Valve driven out of service");
  AST_AUTO_CMD: assert property (is_auto && state == vsu_pkg::ST_IDLE && !test_go |=> o_valve == $past(cmd)) // R3
    else $error("Valve does not follow setpoint");
  AST_MEAS_START: assert property (is_auto && tm_en && cmd_chg |=> state == vsu_pkg::ST_BREAK && tcnt == 16'h0000) // R4
    else $error("Measurement did not start");
  AST_ALARM: assert property ((st_ba | st_tr) |=> t_alm[$past(st_idx)] == $past(win_bad)) // R5
    else $error("Time alarm wrong");
  AST_MEAS_HOLD: assert property ((st_ba | st_tr) |=> meas[$past(st_idx)] == $past(tcnt)) // R6
    else $error("Measured time not stored");
  AST_REF_RANGE: assert property (ref_t[0] <= vsu_pkg::BREAK_MAX && ref_t[1] <= vsu_pkg::TRANSIT_MAX
                                  && ref_t[2] <= vsu_pkg::BREAK_MAX && dev[3] <= vsu_pkg::DEV_MAX) // R8
    else $error("Reference out of range");
  AST_TICK_COUNT: assert property (tick && !clr_t && tcnt != vsu_pkg::TCNT_MAX |=> tcnt == $past(tcnt) + 16'h0001) // R9
    else $error("Time count missed a tick");
  AST_TEST_NEEDS_TM: assert property (state == vsu_pkg::ST_IDLE ##1 in_test |-> $past(tm_en)) // R11
    else $error("Test without time supervision");
  AST_TEST_DRIVE: assert property (state == vsu_pkg::ST_TEST_BREAK [*2] |-> o_valve == ~cmd) // R12
    else $error("Test not driving opposite");
  AST_STROKE_INC: assert property (stroke_inc && !(wr & a_stroke) |=> stroke_cnt == $past(stroke_cnt) + 32'h00000001) // R16
    else $error("Stroke not counted");
  AST_MAINT_OFF: assert property ((stroke_lim == 32'h00000000) [*2] |-> !o_maint_alarm) // R18
    else $error("Maintenance alarm with zero limit");
  AST_LEAD_MAP: assert property (##1 $stable(lead_mon) && $stable(sync_q) |-> lead_fault == (sync_q[7:2] & lead_mon)) // R20
    else $error("Lead fault layout wrong");

  COV_TRANSIT: cover property (st_tr);
  COV_TEST_DONE: cover property (state == vsu_pkg::ST_TEST_RETURN ##1 state == vsu_pkg::ST_IDLE);
  COV_STROKE: cover property (stroke_inc);
  COV_ALARM: cover property ((st_ba | st_tr) && win_bad);
endmodule : vsu_top

// ==== verification/vsu_valve_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Actuator with two end contacts
// ----------------------------------------
module vsu_valve_model #(
  parameter int TRAVEL = 600
) (
  input wire logic i_mclk,
  input wire logic i_valve,
  output logic o_fb_a,
  output logic o_fb_b
);
  int pos = 0;
  // Energised drives open; undriven springs back to closed
  always @(posedge i_mclk)
  begin
    if (i_valve && pos < TRAVEL)
      pos <= pos + 1;
    else if (!i_valve && pos > 0)
      pos <= pos - 1;
  end
  assign o_fb_a = pos >= TRAVEL * 2 / 3;
  assign o_fb_b = pos <= TRAVEL / 3;
endmodule : vsu_valve_model

// ==== verification/test_valve_supervision_unit.sv ====
`timescale 1ns/1ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module test_valve_supervision_unit;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic o_pready, o_pslverr, i_fb_a, i_fb_b, o_valve, o_test_active, o_maint_alarm;
  logic [5:0] i_lead_det = 6'h00, m;
  logic [65:0] exq[$], e;
  localparam logic [32:0] F = 33'h1ffffffff;
  int mismatches = 0, samples_checked = 0, cyc = 0, n, k;
  // Short tick keeps each breakaway near 50 ticks
  vsu_top #(.TICK_CYCLES(4)) vsu_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_fb_a(i_fb_a),
    .i_fb_b(i_fb_b), .i_lead_det(i_lead_det), .o_valve(o_valve),
    .o_test_active(o_test_active), .o_maint_alarm(o_maint_alarm));
  vsu_valve_model vsu_valve_model_i (.i_mclk(i_mclk), .i_valve(o_valve), .o_fb_a(i_fb_a), .o_fb_b(i_fb_b));
  initial
  begin
    forever #20 i_mclk = ~i_mclk;
  end
  // Hang guard
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      results;
    end
  end
  // Read answers checked against the oldest note, masked
  always @(posedge i_mclk)
  begin
    if (i_psel && i_penable && o_pready && !i_pwrite)
    begin
      e = exq.pop_front();
      `CHK({o_pslverr, o_prdata} & e[65:33], e[32:0])
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [65:0] x);
    if (!w)
      exq.push_back(x);
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    // Hold the request until pready is sampled at a rising edge
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 66'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] k);
    apb(1'b0, a, 32'h0, {k, x});
  endtask : rd
  // Wait for an end contact, then let the valve reach its stop
  task automatic wait_fb(input logic o);
    n = 0;
    while ((o ? i_fb_a : i_fb_b) !== 1'b1 && n < 2000)
    begin
      @(posedge i_mclk);
      n++;
    end
    repeat (210) @(posedge i_mclk);
    `CHK(n < 2000, 1'b1)
  endtask : wait_fb
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  initial
  begin
    void'($urandom(97038));
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(vsu_pkg::ADDR_CTRL, 33'h0, F);
    `CHK(o_valve, 1'b0)
    rd(vsu_pkg::ADDR_REF0, 33'h1e0000, 33'h7f0000);
    rd(vsu_pkg::ADDR_PERIOD, 33'h15180, F);
    rd(8'h40, 33'h100000000, F);
    wr(vsu_pkg::ADDR_REF0, 32'h00ffffff);
    rd(vsu_pkg::ADDR_REF0, 33'h641770, F);
    $display("test reset and ranges done");
    // reference 50 ticks, deviation 30 percent
    wr(vsu_pkg::ADDR_REF0, 32'h001e0032);
    wr(vsu_pkg::ADDR_CTRL, 32'h25);
    wr(vsu_pkg::ADDR_SETPT, 32'h1);
    repeat (8) @(posedge i_mclk);
    `CHK(o_valve, 1'b0)
    wr(vsu_pkg::ADDR_SETPT, 32'h101);
    repeat (2) @(posedge i_mclk);
    `CHK(o_valve, 1'b1)
    wait_fb(1'b1);
    rd(vsu_pkg::ADDR_STATUS, 33'h0, 33'h40);
    rd(vsu_pkg::ADDR_MEAS0, 33'h30, 33'hfff0);
    wr(vsu_pkg::ADDR_STROKE, 32'h0);
    wr(vsu_pkg::ADDR_SETPT, 32'h100);
    wait_fb(1'b0);
    rd(vsu_pkg::ADDR_MEAS0 + 8'h08, 33'h30, 33'hfff0);
    wr(vsu_pkg::ADDR_REF0, 32'h00000001);
    wr(vsu_pkg::ADDR_SETPT, 32'h101);
    wait_fb(1'b1);
    rd(vsu_pkg::ADDR_STATUS, 33'h40, 33'h40);
    rd(vsu_pkg::ADDR_MEAS0, 33'h30, 33'hfff0);
    rd(vsu_pkg::ADDR_STROKE, 33'h1, F);
    $display("test timing and stroke done");
    wr(vsu_pkg::ADDR_LIMIT, 32'h3);
    wr(vsu_pkg::ADDR_STROKE, 32'h5);
    repeat (3) @(posedge i_mclk);
    `CHK(o_maint_alarm, 1'b1)
    wr(vsu_pkg::ADDR_LIMIT, 32'h0);
    repeat (3) @(posedge i_mclk);
    `CHK(o_maint_alarm, 1'b0)
    rd(vsu_pkg::ADDR_STROKE, 33'h5, F);
    // test from open, breakaway lands in entry 2
    wr(vsu_pkg::ADDR_REF0 + 8'h08, 32'h001e0032);
    wr(vsu_pkg::ADDR_PERIOD, 32'ha);
    wr(vsu_pkg::ADDR_CTRL, 32'h2d);
    n = 0;
    while (o_test_active !== 1'b1 && n < 6000)
    begin
      @(posedge i_mclk);
      n++;
    end
    `CHK(n < 6000, 1'b1)
    `CHK(o_valve, 1'b0)
    n = 0;
    while (o_test_active !== 1'b0 && n < 1000)
    begin
      @(posedge i_mclk);
      n++;
    end
    `CHK(n < 1000, 1'b1)
    `CHK(o_valve, 1'b1)
    rd(vsu_pkg::ADDR_STATUS, 33'h0, 33'h100);
    rd(vsu_pkg::ADDR_MEAS0 + 8'h08, 33'h30, 33'hfff0);
    wr(vsu_pkg::ADDR_CTRL, 32'h0);
    repeat (3) @(posedge i_mclk);
    `CHK(o_valve, 1'b0)
    // Manual drive with both sensors set to substitute
    wr(vsu_pkg::ADDR_CTRL, 32'h742);
    repeat (3) @(posedge i_mclk);
    `CHK(o_valve, 1'b1)
    $display("test limit and idle done");
    // Random faults against random enables
    for (k = 0; k < 4; k++)
    begin
      m = 6'($urandom);
      i_lead_det <= 6'($urandom);
      wr(vsu_pkg::ADDR_LEADMON, {26'h0, m});
      m = m & i_lead_det;
      repeat (8) @(posedge i_mclk);
      rd(vsu_pkg::ADDR_STATUS, {18'h0, |m[3:2], ~|m[1:0], 7'h0, m}, 33'h603f);
    end
    $display("test lead faults done");
    results;
  end
endmodule : test_valve_supervision_unit
